// >>> common/fpk_pkg.sv
// Constants and types for the front-panel key controller.
// Assumes one system clock; every pin input except four_chan_mode and resetn is synchronised inside the core.
package fpk_pkg;

   // ==========================================================
   // Sizes
   localparam int unsigned COLS = 8;
   localparam int unsigned ROWS = 7;
   localparam int unsigned FRAME_BITS = 8;
   localparam int unsigned SYNC_W = 30;

   // ==========================================================
   // Positions inside the synchronised input vector
   localparam int unsigned P_COL = 0;
   localparam int unsigned P_ROW = 8;
   localparam int unsigned P_KA = 15;
   localparam int unsigned P_KB = 16;
   localparam int unsigned P_SCL = 17;
   localparam int unsigned P_SDA = 18;
   localparam int unsigned P_BEEP = 19;
   localparam int unsigned P_CRST = 20;
   localparam int unsigned P_HR = 21;
   localparam int unsigned P_OV = 25;
   localparam int unsigned P_SRC = 29;

   // ==========================================================
   // Record byte layout
   localparam int unsigned REC_KNOB_BIT = 7;
   localparam logic [7:0] REC_RST = 8'h00;

   // ==========================================================
   // Link
   localparam logic [6:0] IIC_ADDR = 7'h20;
   localparam logic [3:0] BITS_PER_FRAME = 4'h8;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned ROW_SETTLE_NS = 200;
   localparam int unsigned ROW_SETTLE_CYC =
      (ROW_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // States
   typedef enum logic [1:0] {K_IDLE, K_ROWSCAN, K_HOLD, K_RELEASE} fpk_kst_t;
   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_DATA, I_DACK} fpk_ist_t;

   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
      logic [SYNC_W-1:0] s3;
      logic [SYNC_W-1:0] flt;
      fpk_kst_t kst;
      logic [2:0] col_idx;
      logic [7:0] tmr;
      logic [7:0] rec;
      logic pend;
      logic [6:0] knob_cnt;
      fpk_ist_t ist;
      logic [7:0] shreg;
      logic [3:0] bitcnt;
      logic sda_oe_n;
      logic sda_out;
      logic [COLS-1:0] col_oe_n;
      logic [COLS-1:0] col_out;
      logic [ROWS-1:0] row_oe_n;
      logic [ROWS-1:0] row_out;
      logic [3:0] hr_led_n;
      logic [3:0] ov_led_n;
      logic src_led_n;
      logic beep;
      logic irq_n;
   } fpk_state_t;

endpackage : fpk_pkg

// >>> hw/fpk_front_panel.sv
// Front-panel key controller: keypad scan, knob decode, IIC record read-out,
// LED drive and beeper pass-through.
// Assumes all pins are asynchronous to sys_clk; the bench resolves wires.
`timescale 1ns/1ps
module fpk_front_panel (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic cpu_reset,
   input wire logic four_chan_mode,
   input wire logic half_range_in_a,
   input wire logic half_range_in_b,
   input wire logic half_range_in_c,
   input wire logic half_range_in_d,
   input wire logic [3:0] chan_overload,
   input wire logic source_on,
   input wire logic beeper_tone_drive,
   input wire logic knob_phase_a,
   input wire logic knob_phase_b,
   input wire logic [fpk_pkg::COLS-1:0] keypad_column_in,
   output logic [fpk_pkg::COLS-1:0] keypad_column_out,
   output logic [fpk_pkg::COLS-1:0] keypad_column_oe_n,
   input wire logic [fpk_pkg::ROWS-1:0] keypad_row_in,
   output logic [fpk_pkg::ROWS-1:0] keypad_row_out,
   output logic [fpk_pkg::ROWS-1:0] keypad_row_oe_n,
   input wire logic iic_scl,
   input wire logic iic_sda_in,
   output logic iic_sda_out,
   output logic iic_sda_oe_n,
   output logic half_range_led_a_n,
   output logic half_range_led_b_n,
   output logic half_range_led_c_n,
   output logic half_range_led_d_n,
   output logic overload_led_a_n,
   output logic overload_led_b_n,
   output logic overload_led_c_n,
   output logic overload_led_d_n,
   output logic source_led_n,
   output logic beeper_out,
   output logic front_panel_irq_n
);
   import fpk_pkg::*;

   // ==========================================================
   // Reset image
   localparam fpk_state_t RST = '{
      s1: '0, s2: '0, s3: '0, flt: '0,
      kst: K_IDLE, col_idx: 3'h0, tmr: 8'h00, rec: REC_RST, pend: 1'b0,
      knob_cnt: 7'h00, ist: I_IDLE, shreg: 8'h00, bitcnt: 4'h0,
      sda_oe_n: 1'b1, sda_out: 1'b0,
      col_oe_n: '1, col_out: '0, row_oe_n: '0, row_out: '0,
      hr_led_n: 4'hf, ov_led_n: 4'hf, src_led_n: 1'b1,
      beep: 1'b0, irq_n: 1'b1};

   fpk_state_t q;
   fpk_state_t n;
   logic [SYNC_W-1:0] pins;
   logic [COLS-1:0] col_fall;
   logic [ROWS-1:0] row_low;
   logic [2:0] fcol;
   logic [2:0] frow;
   logic step;
   logic cw;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic read_done;

   assign pins = {source_on, chan_overload, half_range_in_d, half_range_in_c,
      half_range_in_b, half_range_in_a, cpu_reset, beeper_tone_drive,
      iic_sda_in, iic_scl, knob_phase_b, knob_phase_a, keypad_row_in,
      keypad_column_in};

   always_comb begin
      n = q;
      fcol = 3'h0;
      frow = 3'h0;
      read_done = 1'b0;
      // ==========================================================
      // Three-stage sync; accept once stages two and three agree
      n.s1 = pins;
      n.s2 = q.s1;
      n.s3 = q.s2;
      n.flt = (q.s2 & q.s3) | (q.flt & (q.s2 ^ q.s3));

      // ==========================================================
      // LEDs and beeper
      n.hr_led_n[0] = ~n.flt[P_HR];
      n.hr_led_n[1] = ~n.flt[P_HR+1];
      n.hr_led_n[2] = ~(four_chan_mode & n.flt[P_HR+2]);
      n.hr_led_n[3] = ~(four_chan_mode & n.flt[P_HR+3]);
      if (four_chan_mode) begin
         n.ov_led_n = ~n.flt[P_OV +: 4];
      end else begin
         n.ov_led_n = {~n.flt[P_OV+1], ~n.flt[P_OV], 2'b11};
      end
      n.src_led_n = ~n.flt[P_SRC];
      n.beep = n.flt[P_BEEP];

      // ==========================================================
      // IIC slave, clock sampled only
      scl_rise = ~q.flt[P_SCL] & n.flt[P_SCL];
      scl_fall = q.flt[P_SCL] & ~n.flt[P_SCL];
      start_c = q.flt[P_SCL] & n.flt[P_SCL] & q.flt[P_SDA] & ~n.flt[P_SDA];
      stop_c = q.flt[P_SCL] & n.flt[P_SCL] & ~q.flt[P_SDA] & n.flt[P_SDA];
      if (start_c) begin
         n.ist = I_ADDR;
         n.bitcnt = 4'h0;
         n.sda_oe_n = 1'b1;
      end else if (stop_c) begin
         n.ist = I_IDLE;
         n.sda_oe_n = 1'b1;
      end else begin
         case (q.ist)
            I_ADDR: begin
               if (scl_rise) begin
                  n.shreg = {q.shreg[6:0], n.flt[P_SDA]};
                  n.bitcnt = q.bitcnt + 4'h1;
               end else if (scl_fall && q.bitcnt == BITS_PER_FRAME) begin
                  if (q.shreg == {IIC_ADDR, 1'b1}) begin
                     n.sda_oe_n = 1'b0;
                     n.ist = I_AACK;
                  end else begin
                     n.ist = I_IDLE;
                  end
               end
            end
            I_AACK: begin
               if (scl_fall) begin
                  n.shreg = q.rec;
                  n.sda_oe_n = q.rec[7];
                  n.bitcnt = 4'h0;
                  n.ist = I_DATA;
               end
            end
            I_DATA: begin
               if (scl_rise) begin
                  n.bitcnt = q.bitcnt + 4'h1;
               end else if (scl_fall) begin
                  if (q.bitcnt == BITS_PER_FRAME) begin
                     n.sda_oe_n = 1'b1;
                     n.ist = I_DACK;
                  end else begin
                     n.shreg = {q.shreg[6:0], 1'b0};
                     n.sda_oe_n = q.shreg[6];
                  end
               end
            end
            I_DACK: begin
               if (scl_rise) begin
                  read_done = 1'b1;
                  n.ist = n.flt[P_SDA] ? I_IDLE : I_AACK;
               end
            end
            default: n.ist = I_IDLE;
         endcase
      end

      // ==========================================================
      // Knob quadrature decode
      step = (q.flt[P_KA] ^ n.flt[P_KA]) ^ (q.flt[P_KB] ^ n.flt[P_KB]);
      cw = q.flt[P_KA] ^ n.flt[P_KB];
      if (step) begin
         n.knob_cnt = cw ? q.knob_cnt + 7'h01 : q.knob_cnt - 7'h01;
      end

      // ==========================================================
      // Keypad scan
      col_fall = q.flt[P_COL +: COLS] & ~n.flt[P_COL +: COLS];
      row_low = ~n.flt[P_ROW +: ROWS];
      for (int i = COLS - 1; i >= 0; i--) begin
         if (col_fall[i]) begin
            fcol = i[2:0];
         end
      end
      for (int i = ROWS - 1; i >= 0; i--) begin
         if (row_low[i]) begin
            frow = i[2:0];
         end
      end
      if (read_done && q.pend) begin
         n.pend = 1'b0;
      end
      case (q.kst)
         K_IDLE: begin
            n.row_oe_n = '0;
            n.row_out = '0;
            if (col_fall != '0 && !q.pend) begin
               n.col_idx = fcol;
               n.row_out = '1;
               n.tmr = 8'(ROW_SETTLE_CYC);
               n.kst = K_ROWSCAN;
            end else if (n.knob_cnt != 7'h00 && !q.pend) begin
               n.rec = {1'b1, n.knob_cnt};
               n.knob_cnt = 7'h00;
               n.pend = 1'b1;
            end
         end
         K_ROWSCAN: begin
            if (q.tmr != 8'h00) begin
               n.tmr = q.tmr - 8'h01;
            end else if (row_low != '0 &&
                  (row_low & (row_low - 1'b1)) == '0) begin
               n.rec = {2'b00, frow, q.col_idx};
               n.pend = 1'b1;
               n.col_oe_n[5:0] = '0;
               n.kst = K_HOLD;
            end else begin
               n.row_out = '0;
               n.kst = K_IDLE;
            end
         end
         K_HOLD: begin
            if (!n.pend) begin
               n.col_oe_n = '1;
               n.row_out = '0;
               n.kst = K_RELEASE;
            end
         end
         K_RELEASE: begin
            if (n.flt[P_COL +: COLS] == '1) begin
               n.kst = K_IDLE;
            end
         end
         default: n.kst = K_IDLE;
      endcase
      n.irq_n = ~n.pend;

      // ==========================================================
      // CPU reset pulse clears all but the synchronisers
      if (n.flt[P_CRST]) begin
         n = RST;
         n.s1 = pins;
         n.s2 = q.s1;
         n.s3 = q.s2;
         n.flt = (q.s2 & q.s3) | (q.flt & (q.s2 ^ q.s3));
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         q <= RST;
      end else begin
         q <= n;
      end
   end

   // ==========================================================
   // Outputs
   assign keypad_column_out = q.col_out;
   assign keypad_column_oe_n = q.col_oe_n;
   assign keypad_row_out = q.row_out;
   assign keypad_row_oe_n = q.row_oe_n;
   assign iic_sda_out = q.sda_out;
   assign iic_sda_oe_n = q.sda_oe_n;
   assign half_range_led_a_n = q.hr_led_n[0];
   assign half_range_led_b_n = q.hr_led_n[1];
   assign half_range_led_c_n = q.hr_led_n[2];
   assign half_range_led_d_n = q.hr_led_n[3];
   assign overload_led_a_n = q.ov_led_n[0];
   assign overload_led_b_n = q.ov_led_n[1];
   assign overload_led_c_n = q.ov_led_n[2];
   assign overload_led_d_n = q.ov_led_n[3];
   assign source_led_n = q.src_led_n;
   assign beeper_out = q.beep;
   assign front_panel_irq_n = q.irq_n;

endmodule : fpk_front_panel

// >>> testbench/fpk_front_panel_sva.sv
// Pin-level checks for the front-panel key controller.
// Assumes it is bound into fpk_front_panel; one clock domain.
`timescale 1ns/1ps
module fpk_front_panel_sva (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic four_chan_mode,
   input wire logic half_range_in_a,
   input wire logic half_range_led_a_n,
   input wire logic half_range_led_c_n,
   input wire logic half_range_led_d_n,
   input wire logic [3:0] chan_overload,
   input wire logic overload_led_a_n,
   input wire logic overload_led_b_n,
   input wire logic overload_led_c_n,
   input wire logic source_on,
   input wire logic source_led_n,
   input wire logic [fpk_pkg::COLS-1:0] keypad_column_oe_n,
   input wire logic iic_scl,
   input wire logic iic_sda_oe_n,
   input wire logic front_panel_irq_n
);
   import fpk_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // ====
   // Lamps
   property p_hr_a; half_range_in_a [*8] |-> !half_range_led_a_n; endproperty
   a_hr_a: assert property (p_hr_a) else $error("lamp a off");
   property p_hr_cd;
      !four_chan_mode [*3] |-> half_range_led_c_n && half_range_led_d_n;
   endproperty
   a_hr_cd: assert property (p_hr_cd) else $error("lamp c or d lit");
   property p_ov_ab;
      !four_chan_mode [*3] |-> overload_led_a_n && overload_led_b_n;
   endproperty
   a_ov_ab: assert property (p_ov_ab) else $error("overload a or b lit");
   property p_ov_c;
      (!four_chan_mode && chan_overload[0]) [*8] |-> !overload_led_c_n;
   endproperty
   a_ov_c: assert property (p_ov_c) else $error("overload c off");
   property p_src; !source_on [*8] |-> source_led_n; endproperty
   a_src: assert property (p_src) else $error("source lamp lit");
   // ====
   // Keypad and link
   property p_key;
      $fell(keypad_column_oe_n[0]) |->
         !front_panel_irq_n && keypad_column_oe_n[5:0] == 6'h00;
   endproperty
   a_key: assert property (p_key) else $error("column drive bad");
   property p_rel;
      $rose(front_panel_irq_n) |-> iic_scl && iic_sda_oe_n;
   endproperty
   a_rel: assert property (p_rel) else $error("early release");
   property p_sda; $fell(iic_sda_oe_n) |-> !iic_scl; endproperty
   a_sda: assert property (p_sda) else $error("data moved on high");
   c_key: cover property ($fell(keypad_column_oe_n[0]));
   c_rel: cover property ($rose(front_panel_irq_n));
   c_sda: cover property ($fell(iic_sda_oe_n));
endmodule : fpk_front_panel_sva
bind fpk_front_panel fpk_front_panel_sva u_sva (.*);

// >>> testbench/fpk_host_model.sv
// Host board model: makes the serial clock and reads records.
// Assumes the data line is resolved outside with a pull-up.
`timescale 1ns/1ps
module fpk_host_model (
   input wire logic sys_clk,
   input wire logic sda_in,
   output logic scl,
   output logic sda_n
);
   // Clock stands high between frames
   initial begin
      scl = 1'b1;
      sda_n = 1'b1;
   end
   task automatic half();
      repeat (16) @(posedge sys_clk);
   endtask : half
   task automatic bit_cyc(input logic b, output logic r);
      repeat (8) @(posedge sys_clk);
      sda_n <= b;
      repeat (8) @(posedge sys_clk);
      scl <= 1'b1;
      half();
      r = sda_in;
      scl <= 1'b0;
   endtask : bit_cyc
   task automatic read_rec(input logic [7:0] adr, output logic ack,
      output logic [7:0] d);
      logic r;
      d = 8'h00;
      half();
      sda_n <= 1'b0;
      half();
      scl <= 1'b0;
      for (int i = 7; i >= 0; i--) bit_cyc(adr[i], r);
      bit_cyc(1'b1, ack);
      if (!ack) begin
         for (int i = 7; i >= 0; i--) bit_cyc(1'b1, d[i]);
         bit_cyc(1'b1, r);
      end
      repeat (8) @(posedge sys_clk);
      sda_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      scl <= 1'b1;
      half();
      sda_n <= 1'b1;
      half();
   endtask : read_rec
endmodule : fpk_host_model

// >>> testbench/fpk_front_panel_tb.sv
// Self-checking bench for the front-panel key controller.
// Assumes the host model on the link and the bound checker.
`timescale 1ns/1ps
module fpk_front_panel_tb;
   import fpk_pkg::*;
   logic sys_clk = 1'b0, resetn = 1'b0, cpu_reset = 1'b0;
   logic four_chan_mode = 1'b0, source_on = 1'b0, beeper_tone_drive = 1'b0;
   logic half_range_in_a = 1'b0, half_range_in_b = 1'b0;
   logic half_range_in_c = 1'b0, half_range_in_d = 1'b0;
   logic knob_phase_a = 1'b0, knob_phase_b = 1'b0;
   logic [3:0] chan_overload = 4'h0;
   logic [7:0] key_col = 8'h00;
   logic [6:0] key_row = 7'h00;
   int n_mismatch = 0, cmp_count = 0;
   wire logic [7:0] keypad_column_out, keypad_column_oe_n;
   wire logic [6:0] keypad_row_out, keypad_row_oe_n;
   wire logic iic_scl, iic_sda_out, iic_sda_oe_n, host_sda_n;
   wire logic half_range_led_a_n, half_range_led_b_n;
   wire logic half_range_led_c_n, half_range_led_d_n;
   wire logic overload_led_a_n, overload_led_b_n;
   wire logic overload_led_c_n, overload_led_d_n;
   wire logic source_led_n, beeper_out, front_panel_irq_n;
   // Pressed key pulls its column and its row low; pulled-up lines
   wire logic [7:0] keypad_column_in =
      ~key_col & (keypad_column_oe_n | keypad_column_out);
   wire logic [6:0] keypad_row_in = keypad_row_out & ~key_row;
   wire logic iic_sda_in = (iic_sda_oe_n | iic_sda_out) & host_sda_n;
   always #2 sys_clk = ~sys_clk;
   fpk_front_panel u_dut (.*);
   fpk_host_model u_host (.sys_clk, .sda_in(iic_sda_in), .scl(iic_scl),
      .sda_n(host_sda_n));
   // ====
   // Helpers
   task automatic final_report();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_irq(input logic lvl);
      for (int i = 0; i < 300 && front_panel_irq_n !== lvl; i++)
         @(posedge sys_clk);
      chk(16'(front_panel_irq_n), 16'(lvl));
   endtask : wait_irq
   task automatic rd(input logic [7:0] adr, input logic ea,
      input logic [7:0] ed);
      logic ack;
      logic [7:0] d;
      u_host.read_rec(adr, ack, d);
      chk({7'h00, ack, d}, {7'h00, ea, ed});
   endtask : rd
   // ====
   // Scenarios
   task automatic t_lamps();
      logic [3:0] h, eh, eo;
      logic [15:0] got;
      for (int m = 0; m < 2; m++) begin
         for (int i = 0; i < 5; i++) begin
            h = 4'h1 << i;
            @(posedge sys_clk);
            four_chan_mode <= m[0];
            {half_range_in_d, half_range_in_c, half_range_in_b,
               half_range_in_a} <= h;
            chan_overload <= h;
            source_on <= i[0];
            beeper_tone_drive <= i[1];
            repeat (8) @(posedge sys_clk);
            eh = ~(h & {m[0], m[0], 2'b11});
            eo = m[0] ? ~h : {~h[1:0], 2'b11};
            got = {6'h00, half_range_led_d_n, half_range_led_c_n,
               half_range_led_b_n, half_range_led_a_n, overload_led_d_n,
               overload_led_c_n, overload_led_b_n, overload_led_a_n,
               source_led_n, beeper_out};
            chk(got, {6'h00, eh, eo, ~i[0], i[1]});
         end
      end
   endtask : t_lamps
   task automatic t_key(input logic [2:0] c, input logic [2:0] r);
      @(posedge sys_clk);
      key_col <= 8'h01 << c;
      key_row <= 7'h01 << r;
      wait_irq(1'b0);
      chk(16'(keypad_column_oe_n), 16'h00c0);
      chk(16'(keypad_row_out), 16'h007f);
      chk({keypad_column_out, keypad_row_oe_n, iic_sda_out}, 16'h0000);
      repeat (100) @(posedge sys_clk);
      chk(16'(front_panel_irq_n), 16'h0000);
      rd({IIC_ADDR, 1'b1}, 1'b0, {2'b00, r, c});
      key_col <= 8'h00;
      key_row <= 7'h00;
      wait_irq(1'b1);
   endtask : t_key
   task automatic t_knob();
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         if (i[0]) knob_phase_a <= ~knob_phase_a;
         else knob_phase_b <= ~knob_phase_b;
         repeat (10) @(posedge sys_clk);
      end
      wait_irq(1'b0);
      rd({IIC_ADDR, 1'b0}, 1'b1, 8'h00);
      wait_irq(1'b0);
      rd({IIC_ADDR, 1'b1}, 1'b0, 8'h81);
      wait_irq(1'b0);
      rd({IIC_ADDR, 1'b1}, 1'b0, 8'h83);
      @(posedge sys_clk);
      knob_phase_a <= 1'b1;
      wait_irq(1'b0);
      rd({IIC_ADDR, 1'b1}, 1'b0, 8'hff);
   endtask : t_knob
   task automatic t_cpu_reset();
      @(posedge sys_clk);
      key_col <= 8'h20;
      key_row <= 7'h08;
      wait_irq(1'b0);
      cpu_reset <= 1'b1;
      key_col <= 8'h00;
      key_row <= 7'h00;
      repeat (6) @(posedge sys_clk);
      cpu_reset <= 1'b0;
      wait_irq(1'b1);
      chk(16'(keypad_column_oe_n), 16'h00ff);
   endtask : t_cpu_reset
   // ====
   // Run
   initial begin
      repeat (30000) @(posedge sys_clk);
      n_mismatch++;
      final_report();
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (8) @(posedge sys_clk);
      t_lamps();
      t_key(3'd0, 3'd0);
      t_key(3'd7, 3'd6);
      t_knob();
      t_cpu_reset();
      final_report();
   end
endmodule : fpk_front_panel_tb
